/* File: core/fpec_pkg.sv */
// Constants, encodings and helpers of the flash program/erase control block
package fpec_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] FPEC_CTRL_OFS   = 12'h000;
  localparam logic [11:0] FPEC_KEY_OFS    = 12'h004;
  localparam logic [11:0] FPEC_STATUS_OFS = 12'h008;

  // ----------------------------------------------------------------
  // Field positions of flash_control
  // ----------------------------------------------------------------
  localparam int FPEC_START_BIT  = 15;
  localparam int FPEC_PERMIT_BIT = 14;
  localparam int FPEC_ERR_BIT    = 13;
  localparam int FPEC_ERASE_BIT  = 6;
  localparam int FPEC_OP_LSB     = 0;
  localparam int FPEC_OP_W       = 4;
  localparam int FPEC_KEY_W      = 8;

  // ----------------------------------------------------------------
  // Field positions of the status register
  // ----------------------------------------------------------------
  localparam int FPEC_ST_BUSY_BIT = 0;
  localparam int FPEC_ST_OPEN_BIT = 1;
  localparam int FPEC_ST_CNT_LSB  = 8;

  // ----------------------------------------------------------------
  // Reset values and key values
  // ----------------------------------------------------------------
  localparam logic [3:0]  FPEC_OP_RST   = 4'h0;
  localparam logic [7:0]  FPEC_KEY_ONE  = 8'h55;
  localparam logic [7:0]  FPEC_KEY_TWO  = 8'hAA;
  localparam logic [31:0] FPEC_RD_ZERO  = 32'h00000000;

  // ----------------------------------------------------------------
  // Operation codes
  // ----------------------------------------------------------------
  localparam logic [3:0] FPEC_OP_BULK   = 4'hF;
  localparam logic [3:0] FPEC_OP_GENSEG = 4'hD;
  localparam logic [3:0] FPEC_OP_SECSEG = 4'hC;
  localparam logic [3:0] FPEC_OP_WORD   = 4'h3;
  localparam logic [3:0] FPEC_OP_PAGE   = 4'h2;
  localparam logic [3:0] FPEC_OP_ROW    = 4'h1;
  localparam logic [3:0] FPEC_OP_CFG    = 4'h0;

  // ----------------------------------------------------------------
  // AHB-Lite codes
  // ----------------------------------------------------------------
  localparam logic [2:0] FPEC_HSIZE_WORD = 3'h2;

  // ----------------------------------------------------------------
  // State encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FPEC_KEY_LOCKED = 2'b00,
    FPEC_KEY_HALF   = 2'b01,
    FPEC_KEY_OPEN   = 2'b10
  } fpec_key_t;

  typedef enum logic {
    FPEC_SEQ_IDLE = 1'b0,
    FPEC_SEQ_RUN  = 1'b1
  } fpec_seq_t;

  // ----------------------------------------------------------------
  // Whether a code names a real operation for the erase setting
  // ----------------------------------------------------------------
  function automatic logic fpec_op_legal(input logic erase, input logic [3:0] op);
    logic ok;
    ok = 1'b0;
    if (erase) begin
      ok = (op == FPEC_OP_BULK) || (op == FPEC_OP_GENSEG) || (op == FPEC_OP_SECSEG) ||
           (op == FPEC_OP_PAGE) || (op == FPEC_OP_CFG);
    end else begin
      ok = (op == FPEC_OP_WORD) || (op == FPEC_OP_ROW) || (op == FPEC_OP_CFG);
    end
    return ok;
  endfunction

endpackage

/* File: core/fpec_regbus_if.sv */
// Register access carrier between the bus slave and the control core
`timescale 1ns/1ps
interface fpec_regbus_if;
  logic        wr;     // One-cycle register write
  logic [11:0] addr;   // Byte offset of the access
  logic [31:0] wdata;  // Write data
  logic [31:0] rdata;  // Read data of addr
  logic        busy;   // Core stalls bus accesses

  modport slave (output wr, addr, wdata, input rdata, busy);
  modport core  (input wr, addr, wdata, output rdata, busy);
endinterface

/* File: core/fpec_ahb_slave.sv */
// AHB-Lite slave front end of the flash program/erase control block
`timescale 1ns/1ps
module fpec_ahb_slave
  import fpec_pkg::*;
(
  input  wire logic    clk_in,
  input  wire logic    nrst_in,
  input  wire logic    hsel_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic    hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic    hready_in,
  output logic [31:0]  hrdata_out,
  output logic         hreadyout_out,
  output logic         hresp_out,
  fpec_regbus_if.slave bus
);

  typedef struct packed {
    logic        pend;
    logic        write;
    logic        word;
    logic [11:0] addr;
    logic        ready;
    logic [31:0] rdata;
  } fpec_slv_t;

  fpec_slv_t r, n;
  logic      exec;

  // ----------------------------------------------------------------
  // Data phase runs once the core is not stalling
  // ----------------------------------------------------------------
  assign exec      = r.pend && !bus.busy;
  assign bus.wr    = exec && r.write && r.word;
  assign bus.addr  = r.addr;
  assign bus.wdata = hwdata_in;

  // Next state of the slave
  always_comb begin
    n = r;
    if (hsel_in && htrans_in[1] && hready_in) begin
      n.pend  = 1'b1;
      n.write = hwrite_in;
      n.word  = (hsize_in == FPEC_HSIZE_WORD);
      n.addr  = haddr_in[11:0];
      n.ready = 1'b0;
    end else if (exec) begin
      n.pend  = 1'b0;
      n.ready = 1'b1;
      n.rdata = (r.write || !r.word) ? FPEC_RD_ZERO : bus.rdata;
    end
  end

  // State register
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      r <= '{pend: 1'b0, write: 1'b0, word: 1'b0, addr: 12'h000,
             ready: 1'b1, rdata: 32'h00000000};
    end else begin
      r <= n;
    end
  end

  assign hrdata_out    = r.rdata;
  assign hreadyout_out = r.ready;
  assign hresp_out     = 1'b0;  // Always OKAY

endmodule

/* File: core/fpec_top.sv */
// Flash program/erase control: control and key registers, unlock, sequencer, holding buffer
//
// Operation
// [R1] Setting start launches the selected self-timed operation; hardware clears start at end.
// [R2] Software writing zero to start does nothing; only completion clears it. A warm reset during a run also clears it here.
// [R3] Write-permit one enables program/erase; zero inhibits every operation.
// [R4] Improper attempts or terminations set the sequence-error flag; normal end clears it.
// [R5] Erase-select chooses erase (one) or program (zero) for the next start.
// [R6] Erase codes: F bulk, D general, C secure segment, 2 page, 0 config byte.
// [R7] Program codes: 3 word, 1 row, 0 config byte; others do nothing.
// [R8] Unlisted codes are unimplemented and start no flash operation.
// [R9] Control bits reset to zero only on power-on reset. A warm reset during a run also clears start here.
// [R10] Control bits 12..7 and 5..4 read as zero.
// [R11] Key register takes a write-only low byte; everything reads zero.
// [R12] Keys 0x55 then 0xAA must precede start for an operation to proceed.
// [R13] The processor stalls while an operation runs until start clears.
// [R14] Software erases the whole eight-row page before rewriting a row.
// [R15] Software loads the page start address before a page erase.
// [R16] Software fills 64 buffer words before row programming with code 0001.
// [R17] Software follows start with two no-ops and waits out programming time.
// [R18] The two key writes come back to back with no write between.
// [R19] Holding buffer keeps 64 words loaded sequentially from one aligned group.
// [R20] Start without unlock or permit starts nothing and sets the error flag.
//
// The AHB-Lite slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module fpec_top
  import fpec_pkg::*;
#(
  parameter int BUF_DEPTH = 64,
  parameter int WORD_W    = 24,
  parameter int FADDR_W   = 24
) (
  input  wire logic               CLK_IN,
  input  wire logic               NRST_IN,
  input  wire logic               SYS_RST_IN,
  input  wire logic               HSEL_IN,
  input  wire logic [1:0]         HTRANS_IN,
  input  wire logic [31:0]        HADDR_IN,
  input  wire logic               HWRITE_IN,
  input  wire logic [2:0]         HSIZE_IN,
  input  wire logic [31:0]        HWDATA_IN,
  input  wire logic               HREADY_IN,
  output logic [31:0]             HRDATA_OUT,
  output logic                    HREADYOUT_OUT,
  output logic                    HRESP_OUT,
  input  wire logic               BUF_LOAD_IN,
  input  wire logic [FADDR_W-1:0] BUF_ADDR_IN,
  input  wire logic [WORD_W-1:0]  BUF_DATA_IN,
  input  wire logic [$clog2(BUF_DEPTH)-1:0] FLASH_BUF_IDX_IN,
  output logic [WORD_W-1:0]       FLASH_BUF_DATA_OUT,
  input  wire logic               FLASH_DONE_IN,
  output logic                    FLASH_START_OUT,
  output logic                    FLASH_ABORT_OUT,
  output logic                    FLASH_ERASE_OUT,
  output logic [3:0]              FLASH_OP_OUT,
  output logic                    CPU_STALL_OUT
);

  localparam int IDX_W = $clog2(BUF_DEPTH);
  localparam int GRP_W = FADDR_W - IDX_W;
  localparam int CNT_W = IDX_W + 1;
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(BUF_DEPTH);
  localparam int KEY_W_L = FPEC_KEY_W;

  // ----------------------------------------------------------------
  // Whole state of the control core
  // ----------------------------------------------------------------
  typedef struct packed {
    logic             start;
    logic             permit;
    logic             err;
    logic             erase;
    logic [3:0]       op;
    fpec_key_t        key;
    fpec_seq_t        seq;
    logic             go;
    logic             abort;
    logic             stall;
    logic [CNT_W-1:0] cnt;
    logic [GRP_W-1:0] group;
    logic             done_s1;
    logic             done_s2;
    logic             done_s3;
  } fpec_core_t;

  fpec_core_t r, n;

  fpec_regbus_if bus ();

  logic                  ctrl_wr;
  logic                  key_wr;
  logic [KEY_W_L-1:0]    key_val;
  logic                  done_rise;
  logic                  buf_take;
  logic [WORD_W-1:0]     buf_mem [BUF_DEPTH];
  logic [WORD_W-1:0]     buf_q_r;

  // ----------------------------------------------------------------
  // Bus front end
  // ----------------------------------------------------------------
  fpec_ahb_slave u_slave (
    .clk_in        (CLK_IN),
    .nrst_in       (NRST_IN),
    .hsel_in       (HSEL_IN),
    .htrans_in     (HTRANS_IN),
    .haddr_in      (HADDR_IN),
    .hwrite_in     (HWRITE_IN),
    .hsize_in      (HSIZE_IN),
    .hwdata_in     (HWDATA_IN),
    .hready_in     (HREADY_IN),
    .hrdata_out    (HRDATA_OUT),
    .hreadyout_out (HREADYOUT_OUT),
    .hresp_out     (HRESP_OUT),
    .bus           (bus.slave)
  );

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  assign ctrl_wr   = bus.wr && (bus.addr == FPEC_CTRL_OFS);
  assign key_wr    = bus.wr && (bus.addr == FPEC_KEY_OFS);
  assign key_val   = bus.wdata[KEY_W_L-1:0];
  assign done_rise = r.done_s2 && !r.done_s3;
  assign bus.busy  = r.stall;  // Accesses wait out a running cycle [R13]

  // Holding buffer accepts only the next word of one aligned group
  assign buf_take = BUF_LOAD_IN && !r.stall && (r.cnt != CNT_FULL) &&
                    (BUF_ADDR_IN[IDX_W-1:0] == r.cnt[IDX_W-1:0]) &&
                    ((r.cnt == '0) ||
                     (BUF_ADDR_IN[FADDR_W-1:IDX_W] == r.group));  // [R19]

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_comb begin
    bus.rdata = FPEC_RD_ZERO;  // Key and unmapped read zero [R11]
    if (bus.addr == FPEC_CTRL_OFS) begin
      bus.rdata[FPEC_START_BIT]  = r.start;
      bus.rdata[FPEC_PERMIT_BIT] = r.permit;
      bus.rdata[FPEC_ERR_BIT]    = r.err;
      bus.rdata[FPEC_ERASE_BIT]  = r.erase;
      bus.rdata[FPEC_OP_LSB +: FPEC_OP_W] = r.op;  // Other bits stay zero [R10]
    end else if (bus.addr == FPEC_STATUS_OFS) begin
      bus.rdata[FPEC_ST_BUSY_BIT] = r.stall;
      bus.rdata[FPEC_ST_OPEN_BIT] = (r.key == FPEC_KEY_OPEN);
      bus.rdata[FPEC_ST_CNT_LSB +: CNT_W] = r.cnt;
    end
  end

  // ----------------------------------------------------------------
  // Next state of the core
  // ----------------------------------------------------------------
  always_comb begin
    n         = r;
    n.go      = 1'b0;
    n.abort   = 1'b0;
    n.done_s1 = FLASH_DONE_IN;
    n.done_s2 = r.done_s1;
    n.done_s3 = r.done_s2;

    // Unlock sequence: any write steps or breaks it
    if (bus.wr) begin
      case (r.key)
        FPEC_KEY_LOCKED: begin
          if (key_wr && key_val == FPEC_KEY_ONE) begin
            n.key = FPEC_KEY_HALF;
          end
        end
        FPEC_KEY_HALF: begin
          if (key_wr && key_val == FPEC_KEY_TWO) begin
            n.key = FPEC_KEY_OPEN;  // [R12]
          end else if (key_wr && key_val == FPEC_KEY_ONE) begin
            n.key = FPEC_KEY_HALF;
          end else begin
            n.key = FPEC_KEY_LOCKED;  // A write between breaks it [R18]
          end
        end
        FPEC_KEY_OPEN: begin
          n.key = FPEC_KEY_LOCKED;  // Unlock serves one write only
        end
        default: begin
          n.key = FPEC_KEY_LOCKED;
        end
      endcase
    end

    // Control register write
    if (ctrl_wr) begin
      n.permit = bus.wdata[FPEC_PERMIT_BIT];
      n.err    = bus.wdata[FPEC_ERR_BIT];
      n.erase  = bus.wdata[FPEC_ERASE_BIT];  // [R5]
      n.op     = bus.wdata[FPEC_OP_LSB +: FPEC_OP_W];
      // Writing zero to start leaves it alone [R2]
      if (bus.wdata[FPEC_START_BIT]) begin
        if (r.key != FPEC_KEY_OPEN || !bus.wdata[FPEC_PERMIT_BIT]) begin
          n.err = 1'b1;  // [R3] [R4] [R20]
        end else if (fpec_op_legal(bus.wdata[FPEC_ERASE_BIT],
                                   bus.wdata[FPEC_OP_LSB +: FPEC_OP_W])) begin
          n.start = 1'b1;  // [R1] [R6] [R7] [R12]
          n.go    = 1'b1;
          n.seq   = FPEC_SEQ_RUN;
          n.stall = 1'b1;  // [R13]
        end
        // Unimplemented code: nothing starts [R8]
      end
    end

    // Sequencer
    case (r.seq)
      FPEC_SEQ_IDLE: begin
        n.stall = n.start;
      end
      FPEC_SEQ_RUN: begin
        if (done_rise) begin
          n.start = 1'b0;  // Hardware ends the cycle [R1]
          n.err   = 1'b0;  // Normal completion [R4]
          n.stall = 1'b0;
          n.seq   = FPEC_SEQ_IDLE;
          if (!r.erase && r.op == FPEC_OP_ROW) begin
            n.cnt = '0;  // Row written, buffer free for next group
          end
        end
      end
      default: begin
        n.seq = FPEC_SEQ_IDLE;
      end
    endcase

    // Holding buffer load
    if (buf_take) begin
      n.cnt = r.cnt + 1'b1;
      if (r.cnt == '0) begin
        n.group = BUF_ADDR_IN[FADDR_W-1:IDX_W];
      end
    end else if (BUF_LOAD_IN) begin
      n.err = 1'b1;  // Out-of-order or foreign-group load [R4] [R19]
    end

    // Warm reset: keeps permit, erase and op, drops unlock and buffer, ends a cycle with the error flag set
    if (SYS_RST_IN) begin
      n.key = FPEC_KEY_LOCKED;
      n.cnt = '0;
      if (r.seq == FPEC_SEQ_RUN) begin
        n.abort = 1'b1;
        n.start = 1'b0;
        n.stall = 1'b0;
        n.err   = 1'b1;  // Improper termination [R4]
        n.seq   = FPEC_SEQ_IDLE;
      end
    end
  end

  // ----------------------------------------------------------------
  // State register: power-on reset only [R9]
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      r <= '{start: 1'b0, permit: 1'b0, err: 1'b0, erase: 1'b0,
             op: FPEC_OP_RST, key: FPEC_KEY_LOCKED, seq: FPEC_SEQ_IDLE,
             go: 1'b0, abort: 1'b0, stall: 1'b0, cnt: '0, group: '0,
             done_s1: 1'b0, done_s2: 1'b0, done_s3: 1'b0};
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------
  // Holding buffer storage and registered read port
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_IN) begin
    if (buf_take) begin
      buf_mem[r.cnt[IDX_W-1:0]] <= BUF_DATA_IN;  // [R19]
    end
  end

  // Read port toward the flash array
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      buf_q_r <= '0;
    end else begin
      buf_q_r <= buf_mem[FLASH_BUF_IDX_IN];
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign FLASH_BUF_DATA_OUT = buf_q_r;
  assign FLASH_START_OUT    = r.go;
  assign FLASH_ABORT_OUT    = r.abort;
  assign FLASH_ERASE_OUT    = r.erase;
  assign FLASH_OP_OUT       = r.op;
  assign CPU_STALL_OUT      = r.stall;

endmodule

/* File: tb/fpec_checker.sv */
// Port-level assertions of the flash program/erase control block
`timescale 1ns/1ps
module fpec_checker (
  input wire logic       CLK_IN,
  input wire logic       NRST_IN,
  input wire logic       SYS_RST_IN,
  input wire logic       HSEL_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic       HREADY_IN,
  input wire logic       HREADYOUT_OUT,
  input wire logic       FLASH_DONE_IN,
  input wire logic       FLASH_START_OUT,
  input wire logic       FLASH_ABORT_OUT,
  input wire logic       FLASH_ERASE_OUT,
  input wire logic [3:0] FLASH_OP_OUT,
  input wire logic       CPU_STALL_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!NRST_IN);
  // ----------------------------------------------------------------
  // Bus access steps
  // ----------------------------------------------------------------
  sequence s_taken;
    HSEL_IN && HTRANS_IN[1] && HREADY_IN && !CPU_STALL_OUT && !FLASH_START_OUT;
  endsequence
  sequence s_one_wait;
    !HREADYOUT_OUT ##1 HREADYOUT_OUT;
  endsequence
  a_idle_two_cycles: assert property (s_taken |=> s_one_wait)
    else $error("idle access did not end after one wait");
  a_ready_not_stalled: assert property ($rose(HREADYOUT_OUT) |-> !$past(CPU_STALL_OUT))
    else $error("access finished during a stall");
  // ----------------------------------------------------------------
  // Launch, run and end of a flash cycle
  // ----------------------------------------------------------------
  a_start_single: assert property (FLASH_START_OUT |=> !FLASH_START_OUT)
    else $error("launch pulse longer than one cycle");
  a_start_stalls: assert property (FLASH_START_OUT |-> CPU_STALL_OUT)
    else $error("launch without stall");
  a_start_legal: assert property (FLASH_START_OUT |-> !$past(CPU_STALL_OUT) &&
    (FLASH_ERASE_OUT ? FLASH_OP_OUT inside {4'hF, 4'hD, 4'hC, 4'h2, 4'h0}
                     : FLASH_OP_OUT inside {4'h3, 4'h1, 4'h0}))
    else $error("launch of an unlisted code or during a run");
  a_done_releases: assert property ($rose(FLASH_DONE_IN) && CPU_STALL_OUT |->
    ##[2:4] !CPU_STALL_OUT)
    else $error("stall kept after completion");
  a_stall_cause: assert property ($fell(CPU_STALL_OUT) |->
    $past(FLASH_DONE_IN, 3) || $past(SYS_RST_IN))
    else $error("stall dropped without completion or warm reset");
  a_abort_cause: assert property (FLASH_ABORT_OUT |->
    $past(SYS_RST_IN) && $past(CPU_STALL_OUT) && !CPU_STALL_OUT)
    else $error("abort without a running cycle and warm reset");
  a_op_stable: assert property (CPU_STALL_OUT && $past(CPU_STALL_OUT) |->
    $stable({FLASH_ERASE_OUT, FLASH_OP_OUT}))
    else $error("operation select changed during a run");
endmodule

bind fpec_top fpec_checker fpec_checker_inst (.CLK_IN, .NRST_IN, .SYS_RST_IN, .HSEL_IN,
  .HTRANS_IN, .HREADY_IN, .HREADYOUT_OUT, .FLASH_DONE_IN, .FLASH_START_OUT,
  .FLASH_ABORT_OUT, .FLASH_ERASE_OUT, .FLASH_OP_OUT, .CPU_STALL_OUT);

/* File: tb/fpec_flash_model.sv */
// Behavioural flash array that ends each launched cycle after a chosen delay
`timescale 1ns/1ps
module fpec_flash_model (
  input  wire logic       clk_in,
  input  wire logic       nrst_in,
  input  wire logic       start_in,
  input  wire logic       abort_in,
  input  wire logic [7:0] delay_in,
  output logic            done_out
);
  int   cnt;
  logic run;
  // Count the delay down, then hold done high until the next launch
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      run      <= 1'b0;
      cnt      <= 0;
      done_out <= 1'b0;
    end else if (abort_in) begin
      run <= 1'b0;
    end else if (start_in) begin
      run      <= 1'b1;
      cnt      <= delay_in;
      done_out <= 1'b0;
    end else if (run && cnt == 0) begin
      run      <= 1'b0;
      done_out <= 1'b1;
    end else if (run) begin
      cnt <= cnt - 1;
    end
  end
endmodule

/* File: tb/tb_flash_program_erase_control.sv */
// Self-checking testbench of the flash program/erase control block
`timescale 1ns/1ps
module tb_flash_program_erase_control;
  import fpec_pkg::*;
  logic        CLK_IN = 1'b0, NRST_IN = 1'b0, SYS_RST_IN = 1'b0, HSEL_IN = 1'b0;
  logic        HWRITE_IN = 1'b0, BUF_LOAD_IN = 1'b0, HREADYOUT_OUT, HRESP_OUT;
  logic [1:0]  HTRANS_IN = 2'h0;
  logic [2:0]  HSIZE_IN = 3'h0;
  logic [31:0] HADDR_IN = 32'h0, HWDATA_IN = 32'h0, HRDATA_OUT, rd, m_ctrl;
  logic [23:0] BUF_ADDR_IN = 24'h0, BUF_DATA_IN = 24'h0, FLASH_BUF_DATA_OUT;
  logic [5:0]  FLASH_BUF_IDX_IN = 6'h0;
  logic [3:0]  FLASH_OP_OUT;
  logic [7:0]  dly = 8'h04;
  logic        FLASH_DONE_IN, FLASH_START_OUT, FLASH_ABORT_OUT, FLASH_ERASE_OUT, CPU_STALL_OUT;
  bit          m_open, m_half, m_go, m_err;
  logic [23:0] q[$];
  int          mismatches = 0, n_tests = 0, n_start = 0, n_abort = 0, n_exp = 0, cyc = 0;
  int          seed = 32'h5BAC;

  fpec_top fpec_top_inst (.CLK_IN, .NRST_IN, .SYS_RST_IN, .HSEL_IN, .HTRANS_IN, .HADDR_IN,
    .HWRITE_IN, .HSIZE_IN, .HWDATA_IN, .HREADY_IN(HREADYOUT_OUT), .HRDATA_OUT, .HREADYOUT_OUT,
    .HRESP_OUT, .BUF_LOAD_IN, .BUF_ADDR_IN, .BUF_DATA_IN, .FLASH_BUF_IDX_IN,
    .FLASH_BUF_DATA_OUT, .FLASH_DONE_IN, .FLASH_START_OUT, .FLASH_ABORT_OUT,
    .FLASH_ERASE_OUT, .FLASH_OP_OUT, .CPU_STALL_OUT);
  fpec_flash_model fpec_flash_model_inst (.clk_in(CLK_IN), .nrst_in(NRST_IN),
    .start_in(FLASH_START_OUT), .abort_in(FLASH_ABORT_OUT), .delay_in(dly),
    .done_out(FLASH_DONE_IN));

  // ----------------------------------------------------------------
  // Clock, launch counters and hang guard
  // ----------------------------------------------------------------
  always #4 CLK_IN = ~CLK_IN;
  always @(posedge CLK_IN) begin
    n_start += int'(FLASH_START_OUT === 1'b1);
    n_abort += int'(FLASH_ABORT_OUT === 1'b1);
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      end_sim();
    end
  end

  // Verdict and end of run
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One single AHB-Lite word transfer; read data lands in rd
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    HSEL_IN   <= 1'b1;
    HTRANS_IN <= 2'h2;
    HADDR_IN  <= {20'h0, a};
    HWRITE_IN <= w;
    HSIZE_IN  <= FPEC_HSIZE_WORD;
    do @(posedge CLK_IN); while (HREADYOUT_OUT !== 1'b1);
    HTRANS_IN <= 2'h0;
    HWDATA_IN <= d;
    do @(posedge CLK_IN); while (HREADYOUT_OUT !== 1'b1);
    rd = HRDATA_OUT;
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
    chk({31'h0, HRESP_OUT}, 32'h0);
  endtask

  function automatic bit legal(input bit e, input bit [3:0] op);
    return e ? op inside {4'hF, 4'hD, 4'hC, 4'h2, 4'h0} : op inside {4'h3, 4'h1, 4'h0};
  endfunction

  // Key and control writes with the reference model of the unlock state
  task automatic wr_key(input logic [7:0] k);
    m_open = m_half && k == FPEC_KEY_TWO;
    m_half = k == FPEC_KEY_ONE;
    bus(1'b1, FPEC_KEY_OFS, {24'h0, k});
  endtask

  task automatic unlock();
    wr_key(FPEC_KEY_ONE);
    wr_key(FPEC_KEY_TWO);
  endtask

  task automatic wr_ctrl(input logic [15:0] v);
    m_go   = v[15] && m_open && v[14] && legal(v[6], v[3:0]);
    m_err  = (v[15] && !(m_open && v[14])) || (v[13] && !m_go);
    m_ctrl = {17'h0, v[14], m_err, 6'h0, v[6], 2'h0, v[3:0]};
    n_exp  += int'(m_go);
    m_open = 1'b0;
    m_half = 1'b0;
    bus(1'b1, FPEC_CTRL_OFS, {16'h0, v});
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge CLK_IN);
    NRST_IN <= 1'b1;
    @(posedge CLK_IN);
    rdchk(FPEC_CTRL_OFS, 32'h0);
    rdchk(12'h00C, 32'h0);
    wr_ctrl(16'hFFFF);
    rdchk(FPEC_CTRL_OFS, m_ctrl);
    wr_ctrl(16'h0000);
    rdchk(FPEC_CTRL_OFS, m_ctrl);
    wr_key(FPEC_KEY_ONE);
    rdchk(FPEC_KEY_OFS, 32'h0);
    wr_key(FPEC_KEY_TWO);
    rdchk(FPEC_STATUS_OFS, 32'h2);
    wr_ctrl(16'h8003);
    rdchk(FPEC_CTRL_OFS, m_ctrl);
    wr_key(FPEC_KEY_ONE);
    wr_ctrl(16'h4003);
    wr_key(FPEC_KEY_TWO);
    wr_ctrl(16'hC003);
    rdchk(FPEC_CTRL_OFS, m_ctrl);
    wr_ctrl(16'h0000);
    // Three aligned loads, then one out of sequence
    for (int i = 0; i < 4; i++) begin
      BUF_LOAD_IN <= 1'b1;
      BUF_ADDR_IN <= 24'h000400 + 24'((i == 3) ? 7 : i); // Page-aligned base
      BUF_DATA_IN <= 24'($random(seed));
      @(posedge CLK_IN);
      if (i < 3) q.push_back(BUF_DATA_IN);
    end
    BUF_LOAD_IN <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      FLASH_BUF_IDX_IN <= 6'(i);
      repeat (2) @(posedge CLK_IN);
      chk({8'h0, FLASH_BUF_DATA_OUT}, {8'h0, q[i]});
    end
    rdchk(FPEC_STATUS_OFS, 32'h0300);
    rdchk(FPEC_CTRL_OFS, 32'h2000);
    // Fill the rest of the aligned group, buffer then full
    for (int i = 3; i < 64; i++) begin
      BUF_LOAD_IN <= 1'b1;
      BUF_ADDR_IN <= 24'h000400 + 24'(i);
      BUF_DATA_IN <= 24'($random(seed));
      @(posedge CLK_IN);
      q.push_back(BUF_DATA_IN);
    end
    BUF_LOAD_IN      <= 1'b0;
    FLASH_BUF_IDX_IN <= 6'h3F;
    repeat (2) @(posedge CLK_IN);
    chk({8'h0, FLASH_BUF_DATA_OUT}, {8'h0, q[63]});
    rdchk(FPEC_STATUS_OFS, 32'h4000);
    // Every code under both erase settings, random array delay
    for (int k = 0; k < 32; k++) begin
      dly <= 8'h04 + 8'($random(seed) & 31);
      unlock();
      wr_ctrl({2'b11, 7'h0, !k[4], 2'h0, k[3:0]}); // Erase codes before row program
      @(posedge CLK_IN); // Idle slot after start
      chk({31'h0, CPU_STALL_OUT}, {31'h0, m_go});
      chk({27'h0, FLASH_ERASE_OUT, FLASH_OP_OUT}, {27'h0, !k[4], k[3:0]});
      rdchk(FPEC_CTRL_OFS, m_ctrl);
      chk(n_start, n_exp);
    end
    rdchk(FPEC_STATUS_OFS, 32'h0); // Row program frees the buffer
    // Warm reset in mid-run keeps permit, erase and op, clears start and sets the error flag
    dly <= 8'hC8;
    unlock();
    wr_ctrl(16'hC042);
    repeat (5) @(posedge CLK_IN);
    SYS_RST_IN <= 1'b1;
    @(posedge CLK_IN);
    SYS_RST_IN <= 1'b0;
    repeat (2) @(posedge CLK_IN);
    chk(n_abort, 1);
    chk({31'h0, CPU_STALL_OUT}, 32'h0);
    rdchk(FPEC_CTRL_OFS, 32'h6042);
    end_sim();
  end
endmodule
